// ===== core/clkdiv_pkg.sv
// Purpose: Shared constants for the per-output clock divider channel
// Assumes: Fast divider clocks arrive as one-cycle tick enables, one per half period
// Notes:   Source codes are four-bit selector values
package clkdiv_pkg;
   localparam int NUM_OUT = 3;
   localparam int MED_W   = 7;
   localparam int SLOW_W  = 25;
   localparam int PWC_W   = 8;
   localparam int AMT_W   = 8;
   localparam int SRC_W   = 4;
   localparam int HCNT_W  = 10;
   localparam int SCNT_W  = 27;
   // Arm source codes
   localparam logic [SRC_W-1:0] ARM_BIT_WRITE  = 4'h1;
   localparam logic [SRC_W-1:0] ARM_SYNTH_LOCK = 4'h2;
   localparam logic [SRC_W-1:0] ARM_LOOP_LOCK  = 4'h3;
   // Trigger source codes
   localparam logic [SRC_W-1:0] TRG_BIT_WRITE  = 4'h0;
   localparam logic [SRC_W-1:0] TRG_SYNTH_LOCK = 4'h1;
   localparam logic [SRC_W-1:0] TRG_LOOP_LOCK  = 4'h2;
   localparam logic [SRC_W-1:0] TRG_LOOP_CLK   = 4'h3;
   // Codes 4..7 select a general-purpose pin by the low two bits
   localparam logic [SRC_W-1:0] SRC_GPIO_BASE  = 4'h4;
   // Shaping needs slow value above this
   localparam logic [SLOW_W-1:0] SHAPE_MIN_SLOW = 25'h000_0001;
   typedef enum logic [1:0] {ADJ_IDLE, ADJ_ARMED, ADJ_BUSY} adj_state_t;
endpackage

// ===== core/medium_stage.sv
// Purpose: Medium-speed divider with one-period phase step
// Assumes: tick marks each half period of the chosen fast divider
// Notes:   Divides by value plus one; zero value follows the fast clock
`timescale 1ns/100ps
`default_nettype none
module medium_stage
   import clkdiv_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             tick,
   input  wire logic [MED_W-1:0] value,
   input  wire logic             adj_req,
   input  wire logic             adj_cancel,
   input  wire logic [AMT_W-1:0] amount,
   output logic                  adj_ack,
   stage_if.src                  med
);
   logic [HCNT_W-1:0] cnt_r;
   logic              pend_r;
   logic [AMT_W-1:0]  amt_r;

   // Each half lasts value+1 ticks, so odd divides stay at 50%
   wire [HCNT_W-1:0] base   = {3'h0, value} + 10'h001;
   wire [HCNT_W-1:0] amt_sx = {{(HCNT_W-AMT_W){amt_r[AMT_W-1]}}, amt_r};
   wire [HCNT_W-1:0] hi_len = pend_r ? base + amt_sx : base;
   wire              last   = (cnt_r <= 10'h001);

   // Step is applied to one high time only, then period returns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r     <= 10'h001;
         pend_r    <= 1'b0;
         amt_r     <= 8'h00;
         adj_ack   <= 1'b0;
         med.rise  <= 1'b0;
         med.fall  <= 1'b0;
         med.level <= 1'b0;
      end else begin
         adj_ack  <= 1'b0;
         med.rise <= 1'b0;
         med.fall <= 1'b0;
         if (tick) begin
            if (last) begin
               med.level <= ~med.level;
               if (!med.level) begin
                  cnt_r    <= hi_len;
                  med.rise <= 1'b1;
                  if (pend_r) begin
                     pend_r  <= 1'b0;
                     adj_ack <= 1'b1;
                  end
               end else begin
                  cnt_r    <= base;
                  med.fall <= 1'b1;
               end
            end else begin
               cnt_r <= cnt_r - 10'h001;
            end
         end
         // New request wins over consumption in the same cycle
         if (adj_cancel) begin
            pend_r <= 1'b0;
         end else if (adj_req) begin
            pend_r <= 1'b1;
            amt_r  <= amount;
         end
      end
   end
endmodule // medium_stage
`default_nettype wire

// ===== core/output_clock_divider_phase_adjust.sv
// Purpose: Per-output clock dividers and arm/trigger phase step engine
// Assumes: All inputs synchronous to clk; fast dividers given as half-period ticks
// Notes:   Frequency limits are configuration duties, not checked here
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Each output takes first or second fast divider as chosen.
// - Seven-bit medium divider feeds a 25-bit slow divider in series.
// - Both dividers give 50% duty for every value, odd included.
// - Slow divider used only with nonzero medium value; zero bypasses medium.
// - Dual mode: positive pin medium clock, negative pin divided by slow+1.
// - Shaping only up to 141.666MHz, medium above 0, slow above 1.
// - Pulse width zero gives 50%; else that many medium periods, polarity set.
// - Shaping happens in slow divider; dual mode shapes negative pin only.
// - Phase step in medium divider, half fast period units.
// - Arm from arm bit write, synth lock, loop lock, or pin.
// - Trigger from bit write, locks, loop clock, pin; invertible.
// - One trigger steps every enabled output with nonzero amount.
// - No phase step when medium divider value is zero.
// - Step changes exactly one medium period; positive lengthens high time.
// - Reset bit cancels pending arm and resets the engine.
// - Report armed, busy, and latched completion flag.
module output_clock_divider_phase_adjust
   import clkdiv_pkg::*;
(
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   input  wire logic                            first_fast_divider,
   input  wire logic                            second_fast_divider,
   input  wire logic [NUM_OUT-1:0]              divider_source_select,
   input  wire logic [NUM_OUT-1:0][MED_W-1:0]   medium_divider_value,
   input  wire logic [NUM_OUT-1:0][SLOW_W-1:0]  slow_divider_value,
   input  wire logic [NUM_OUT-1:0]              slow_divider_select,
   input  wire logic [NUM_OUT-1:0]              negative_pin_slow_divide,
   input  wire logic [NUM_OUT-1:0][PWC_W-1:0]   pulse_width_count,
   input  wire logic [NUM_OUT-1:0]              output_invert,
   input  wire logic [NUM_OUT-1:0]              phase_step_enable,
   input  wire logic [NUM_OUT-1:0][AMT_W-1:0]   phase_step_amount,
   input  wire logic                            phase_mode,
   input  wire logic                            arm_bit,
   input  wire logic                            trigger_bit,
   input  wire logic                            trigger_invert,
   input  wire logic [SRC_W-1:0]                arm_source_select,
   input  wire logic [SRC_W-1:0]                trigger_source_select,
   input  wire logic                            phase_reset,
   input  wire logic                            done_clear,
   input  wire logic                            synth_lock,
   input  wire logic                            loop_lock,
   input  wire logic                            loop_ref_clk,
   input  wire logic [3:0]                      gpio,
   output logic [NUM_OUT-1:0]                   positive_output_pin,
   output logic [NUM_OUT-1:0]                   negative_output_pin,
   output logic                                 armed,
   output logic                                 busy,
   output logic                                 adjust_done_latched
);
   adj_state_t         state_r;
   adj_state_t         state_nxt;
   logic [NUM_OUT-1:0] pend_r;
   logic [NUM_OUT-1:0] pend_nxt;
   logic [NUM_OUT-1:0] req_r;
   logic               done_set;
   logic               arm_prev_r;
   logic               trg_prev_r;
   logic [NUM_OUT-1:0] ack;
   logic [NUM_OUT-1:0] slow_lvl;

   // Pick a source level from a four-bit code; pins use the low two bits
   function automatic logic pick_src(input logic [SRC_W-1:0] code,
                                     input logic [SRC_W-1:0] c_bit,
                                     input logic [SRC_W-1:0] c_syn,
                                     input logic [SRC_W-1:0] c_loop,
                                     input logic [SRC_W-1:0] c_clk,
                                     input logic bit_in,
                                     input logic syn_in,
                                     input logic loop_in,
                                     input logic clk_in,
                                     input logic [3:0] pins);
      logic r;
      r = 1'b0;
      if (code >= SRC_GPIO_BASE && code < SRC_GPIO_BASE + 4'h4) begin
         r = pins[code[1:0]];
      end else if (code == c_bit) begin
         r = bit_in;
      end else if (code == c_syn) begin
         r = syn_in;
      end else if (code == c_loop) begin
         r = loop_in;
      end else if (code == c_clk) begin
         r = clk_in;
      end
      return r;
   endfunction

   // Arm and trigger levels; edges found against last cycle
   // Every level is an argument, since a continuous call only wakes on its arguments
   // Arm has no loop clock source, so that slot is tied low
   wire arm_lvl = pick_src(arm_source_select, ARM_BIT_WRITE, ARM_SYNTH_LOCK,
                           ARM_LOOP_LOCK, 4'hF, arm_bit, synth_lock, loop_lock,
                           1'b0, gpio);
   wire trg_raw = pick_src(trigger_source_select, TRG_BIT_WRITE, TRG_SYNTH_LOCK,
                           TRG_LOOP_LOCK, TRG_LOOP_CLK, trigger_bit, synth_lock,
                           loop_lock, loop_ref_clk, gpio);
   wire trg_lvl = trg_raw ^ trigger_invert;
   wire arm_evt = arm_lvl & ~arm_prev_r;
   wire trg_evt = trg_lvl & ~trg_prev_r;

   // Outputs that take part in a step
   logic [NUM_OUT-1:0] qual;
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         qual[i] = phase_step_enable[i] && (phase_step_amount[i] != 8'h00)
                   && (medium_divider_value[i] != 7'h00);
      end
   end

   // Engine next state; reset bit overrides everything
   always_comb begin
      state_nxt = state_r;
      pend_nxt  = pend_r & ~ack;
      done_set  = 1'b0;
      case (state_r)
         ADJ_IDLE: begin
            if (arm_evt && phase_mode) begin
               state_nxt = ADJ_ARMED;
            end
         end
         ADJ_ARMED: begin
            if (trg_evt) begin
               pend_nxt  = qual;
               state_nxt = (qual == '0) ? ADJ_IDLE : ADJ_BUSY;
               done_set  = (qual == '0);
            end
         end
         ADJ_BUSY: begin
            if (pend_nxt == '0) begin
               state_nxt = ADJ_IDLE;
               done_set  = 1'b1;
            end
         end
         default: begin
            state_nxt = ADJ_IDLE;
         end
      endcase
      if (phase_reset) begin
         state_nxt = ADJ_IDLE;
         pend_nxt  = '0;
         done_set  = 1'b0;
      end
   end

   // Engine registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= ADJ_IDLE;
         pend_r     <= '0;
         req_r      <= '0;
         arm_prev_r <= 1'b0;
         trg_prev_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         pend_r     <= pend_nxt;
         req_r      <= (state_r == ADJ_ARMED && trg_evt && !phase_reset) ? qual : '0;
         arm_prev_r <= arm_lvl;
         trg_prev_r <= trg_lvl;
      end
   end

   // Status; a completion in the clear cycle still latches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed               <= 1'b0;
         busy                <= 1'b0;
         adjust_done_latched <= 1'b0;
      end else begin
         armed <= (state_nxt == ADJ_ARMED);
         busy  <= (state_nxt == ADJ_BUSY);
         adjust_done_latched <= done_set | (adjust_done_latched & ~done_clear);
      end
   end

   // Per-output divider chain
   for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
      stage_if med_bus ();
      wire fast_tick = divider_source_select[g] ? second_fast_divider
                                                : first_fast_divider;
      wire ms_on     = (medium_divider_value[g] != 7'h00);
      // Shaping needs medium above zero and slow above one
      wire shape_en  = ms_on && (slow_divider_value[g] > SHAPE_MIN_SLOW)
                       && (pulse_width_count[g] != 8'h00);
      wire dual      = !slow_divider_select[g] && negative_pin_slow_divide[g];
      wire use_slow  = ms_on && slow_divider_select[g];
      // Slow level feeds the pin only in slow or dual mode
      wire pos_lvl   = use_slow ? slow_lvl[g] : med_bus.level;
      wire neg_lvl   = (dual && ms_on) ? slow_lvl[g] : pos_lvl;

      medium_stage u_med (
         .clk        (clk),
         .rst_n      (rst_n),
         .tick       (fast_tick),
         .value      (medium_divider_value[g]),
         .adj_req    (req_r[g]),
         .adj_cancel (phase_reset),
         .amount     (phase_step_amount[g]),
         .adj_ack    (ack[g]),
         .med        (med_bus)
      );

      slow_stage u_slow (
         .clk         (clk),
         .rst_n       (rst_n),
         .value       (slow_divider_value[g]),
         .pulse_width (pulse_width_count[g]),
         .shape_en    (shape_en),
         .med         (med_bus),
         .level       (slow_lvl[g])
      );

      // Inversion flips pulse polarity, not step direction
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            positive_output_pin[g] <= 1'b0;
            negative_output_pin[g] <= 1'b0;
         end else begin
            positive_output_pin[g] <= pos_lvl ^ output_invert[g];
            negative_output_pin[g] <= neg_lvl ^ output_invert[g];
         end
      end
   end
endmodule // output_clock_divider_phase_adjust
`default_nettype wire

// ===== core/slow_stage.sv
// Purpose: Slow divider with optional pulse shaping
// Assumes: Medium edges arrive as one-cycle pulses on the interface
// Notes:   Divides by value plus one in medium periods
`timescale 1ns/100ps
`default_nettype none
module slow_stage
   import clkdiv_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [SLOW_W-1:0] value,
   input  wire logic [PWC_W-1:0]  pulse_width,
   input  wire logic              shape_en,
   stage_if.snk                   med,
   output logic                   level
);
   logic [SCNT_W-1:0] cnt_r;

   // Count medium half periods, period is twice the divide
   wire [SCNT_W-1:0] n_half = {2'b00, value} + 27'h000_0001;
   wire [SCNT_W-1:0] top    = {n_half[SCNT_W-2:0], 1'b0} - 27'h000_0001;
   wire [SCNT_W-1:0] hi_len = shape_en ? {18'h0_0000, pulse_width, 1'b0} : n_half;
   wire              step   = med.rise | med.fall;
   wire [SCNT_W-1:0] cnt_nxt = (cnt_r >= top) ? 27'h000_0000 : cnt_r + 27'h000_0001;

   // Start counter at wrap so the first medium rise opens a high time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 27'h7FF_FFFF;
         level <= 1'b0;
      end else if (step) begin
         cnt_r <= cnt_nxt;
         level <= (cnt_nxt < hi_len);
      end
   end
endmodule // slow_stage
`default_nettype wire

// ===== core/stage_if.sv
// Purpose: Medium divider edges handed to the slow divider
// Assumes: One clock; rise and fall are one-cycle pulses
// Notes:   level mirrors the medium divider output
`timescale 1ns/100ps
`default_nettype none
interface stage_if;
   logic rise;
   logic fall;
   logic level;
   modport src (output rise, output fall, output level);
   modport snk (input rise, input fall, input level);
endinterface
`default_nettype wire

// ===== test/clkdiv_properties.sv
// Purpose: Port-level checks of the divider channel and phase step engine
// Assumes: One clock domain; rst_n asynchronous, active low
// Notes:   Bound to the top module; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module clkdiv_checker
   import clkdiv_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               phase_mode,
   input wire logic               arm_bit,
   input wire logic [SRC_W-1:0]   arm_source_select,
   input wire logic               phase_reset,
   input wire logic               done_clear,
   input wire logic [NUM_OUT-1:0] slow_divider_select,
   input wire logic [NUM_OUT-1:0] negative_pin_slow_divide,
   input wire logic [NUM_OUT-1:0] positive_output_pin,
   input wire logic [NUM_OUT-1:0] negative_output_pin,
   input wire logic               armed,
   input wire logic               busy,
   input wire logic               adjust_done_latched
);
   // One domain, so clock and reset are stated once
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Plain mode: both pins carry the same clock
   wire logic plain_mode = !slow_divider_select[0] && !negative_pin_slow_divide[0];

   // Engine status relations and plain-mode pin match
   status_exclusive_a: assert property (!(armed && busy))
      else $error("armed and busy at once");
   reset_cancels_a: assert property (phase_reset |=> !armed && !busy)
      else $error("engine not idle after reset bit");
   arm_needs_mode_a: assert property ($rose(armed) |-> $past(phase_mode))
      else $error("armed without phase mode");
   // Reset bit aborts the attempt, since it may cancel the arm in flight
   arm_bit_accept_a: assert property (disable iff (!rst_n || phase_reset)
      $rose(arm_bit) && phase_mode && !armed && !busy && arm_source_select == ARM_BIT_WRITE
      |-> ##[1:3] (armed || busy)) else $error("arm bit edge not taken");
   busy_from_armed_a: assert property ($rose(busy) |-> $past(armed))
      else $error("busy without being armed");
   busy_bounded_a: assert property ($rose(busy) |-> ##[1:600] !busy)
      else $error("step never completed");
   done_cause_a: assert property ($rose(adjust_done_latched) |-> $past(busy) || $past(armed))
      else $error("done flag without an adjustment");
   done_sticky_a: assert property (
      adjust_done_latched && !done_clear && !phase_reset |=> adjust_done_latched)
      else $error("done flag dropped by itself");
   done_clear_a: assert property (done_clear && !busy && !armed |=> !adjust_done_latched)
      else $error("done flag not cleared");
   pins_match_a: assert property (
      plain_mode && $past(plain_mode) |-> positive_output_pin[0] == negative_output_pin[0])
      else $error("pins differ outside dual mode");
endmodule // clkdiv_checker

bind output_clock_divider_phase_adjust clkdiv_checker u_chk (.clk, .rst_n, .phase_mode,
   .arm_bit, .arm_source_select, .phase_reset, .done_clear, .slow_divider_select,
   .negative_pin_slow_divide, .positive_output_pin, .negative_output_pin, .armed, .busy,
   .adjust_done_latched);
`default_nettype wire

// ===== test/clock_sink_model.sv
// Purpose: Downstream clock receiver measuring high and low times
// Assumes: Pin is a registered level sampled on clk
// Notes:   Lengths are in master clock cycles of the last finished phase
`timescale 1ns/100ps
`default_nettype none
module clock_sink_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        pin,
   output logic      [15:0] high_len,
   output logic      [15:0] low_len
);
   logic [15:0] run_r;
   logic        last_r;
   // Length of a phase lands when the pin changes; any phase is at least 10ns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r    <= 16'h0001;
         last_r   <= 1'b0;
         high_len <= 16'h0000;
         low_len  <= 16'h0000;
      end else if (pin !== last_r) begin
         if (last_r) high_len <= run_r;
         else low_len <= run_r;
         run_r  <= 16'h0001;
         last_r <= pin;
      end else begin
         run_r <= run_r + 16'h0001;
      end
   end
endmodule // clock_sink_model
`default_nettype wire

// ===== test/output_clock_divider_phase_adjust_bench.sv
// Purpose: Self-checking bench for the divider channel and phase steps
// Assumes: First fast divider ticks every cycle, second every other cycle
// Notes:   Inputs change at the falling edge; pin times read by sink models
`timescale 1ns/100ps
`default_nettype none
module output_clock_divider_phase_adjust_bench
   import clkdiv_pkg::*;
();
   typedef struct packed {
      logic src; logic [MED_W-1:0] med; logic [SLOW_W-1:0] slow;
      logic sel; logic dual; logic inv; logic [PWC_W-1:0] pwc;
      logic [15:0] ph; logic [15:0] pl; logic [15:0] nh; logic [15:0] nl;
   } row_t;
   logic clk = 1'b0, rst_n = 1'b0, first_fast_divider = 1'b1, second_fast_divider = 1'b0;
   logic [NUM_OUT-1:0] divider_source_select, slow_divider_select, negative_pin_slow_divide;
   logic [NUM_OUT-1:0] output_invert, phase_step_enable;
   logic [NUM_OUT-1:0][MED_W-1:0]  medium_divider_value;
   logic [NUM_OUT-1:0][SLOW_W-1:0] slow_divider_value;
   logic [NUM_OUT-1:0][PWC_W-1:0]  pulse_width_count;
   logic [NUM_OUT-1:0][AMT_W-1:0]  phase_step_amount;
   logic phase_mode, arm_bit, trigger_bit, trigger_invert, phase_reset, done_clear;
   logic synth_lock, loop_lock, loop_ref_clk;
   logic [SRC_W-1:0] arm_source_select, trigger_source_select;
   logic [3:0] gpio;
   logic [NUM_OUT-1:0] positive_output_pin, negative_output_pin;
   logic armed, busy, adjust_done_latched;
   int bad_count = 0, n_tests = 0, cycles = 0, k, n;
   wire logic [15:0] hi_len [NUM_OUT+1];
   wire logic [15:0] lo_len [NUM_OUT+1];
   wire logic [NUM_OUT:0] watched = {negative_output_pin[0], positive_output_pin};
   // Config per row applies to all outputs; pin times of output 0 are checked
   row_t rows [10] = '{
      '{0, 1, 0, 0, 0, 0, 0, 2, 2, 2, 2},
      '{1, 2, 0, 0, 0, 0, 0, 6, 6, 6, 6},
      '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1},
      '{0, 1, 2, 1, 0, 0, 0, 6, 6, 6, 6},
      '{0, 5, 3, 0, 1, 0, 0, 6, 6, 24, 24},
      '{0, 1, 3, 1, 0, 0, 1, 4, 12, 4, 12},
      '{0, 1, 3, 1, 0, 1, 1, 12, 4, 12, 4},
      '{0, 5, 3, 0, 1, 0, 1, 6, 6, 12, 36},
      '{0, 1, 3, 0, 0, 0, 3, 2, 2, 2, 2},
      '{0, 1, 1, 1, 0, 0, 1, 4, 4, 4, 4}};
   // Arm and trigger codes paired so no source drives both at once
   logic [3:0] arm_codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h1};
   logic [3:0] trg_codes [8] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h4, 4'h5, 4'h6, 4'h7};

   output_clock_divider_phase_adjust u_dut (.clk, .rst_n, .first_fast_divider,
      .second_fast_divider, .divider_source_select, .medium_divider_value, .slow_divider_value,
      .slow_divider_select, .negative_pin_slow_divide, .pulse_width_count, .output_invert,
      .phase_step_enable, .phase_step_amount, .phase_mode, .arm_bit, .trigger_bit,
      .trigger_invert, .arm_source_select, .trigger_source_select, .phase_reset, .done_clear,
      .synth_lock, .loop_lock, .loop_ref_clk, .gpio, .positive_output_pin, .negative_output_pin,
      .armed, .busy, .adjust_done_latched);
   for (genvar g = 0; g <= NUM_OUT; g++) begin : g_sink
      clock_sink_model u_sink (.clk, .rst_n, .pin(watched[g]), .high_len(hi_len[g]),
         .low_len(lo_len[g]));
   end

   // Clock, slower fast-divider ticks and hang guard
   always #5 clk = ~clk;
   always @(negedge clk) second_fast_divider <= ~second_fast_divider;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic step(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic apply(input row_t r);
      for (int i = 0; i < NUM_OUT; i++) begin
         divider_source_select[i] = r.src;
         medium_divider_value[i] = r.med;
         slow_divider_value[i] = r.slow;
         slow_divider_select[i] = r.sel;
         negative_pin_slow_divide[i] = r.dual;
         pulse_width_count[i] = r.pwc;
         output_invert[i] = r.inv;
      end
   endtask
   // Unified source index: 0 bit, 1 synth lock, 2 loop lock, 3 loop clock, 4..7 pins
   task automatic drive_src(input logic [3:0] idx, input logic trg, input logic v);
      case (idx)
         4'h0: if (trg) trigger_bit = v; else arm_bit = v;
         4'h1: synth_lock = v;
         4'h2: loop_lock = v;
         4'h3: loop_ref_clk = v;
         default: gpio[idx[1:0]] = v;
      endcase
   endtask
   task automatic engine_reset(input logic clr);
      phase_reset = 1'b1;
      done_clear = clr;
      step(1);
      phase_reset = 1'b0;
      done_clear = 1'b0;
      step(1);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      apply(rows[0]);
      {phase_step_enable, phase_step_amount, phase_mode, arm_bit, trigger_bit} = '0;
      {trigger_invert, phase_reset, done_clear, synth_lock, loop_lock, loop_ref_clk} = '0;
      {arm_source_select, trigger_source_select, gpio} = '0;
      step(5);
      check({positive_output_pin, negative_output_pin, armed, busy, adjust_done_latched}, 0);
      rst_n = 1'b1;
      for (k = 0; k < 10; k++) begin
         apply(rows[k]);
         step(200);
         check({hi_len[0], lo_len[0], hi_len[3], lo_len[3]},
               {rows[k].ph, rows[k].pl, rows[k].nh, rows[k].nl});
         $display("divider row %0d finished", k);
      end
      // Every arm and trigger source; enabled outputs with zero amount finish at once
      phase_mode = 1'b1;
      phase_step_enable = 3'b111;
      for (k = 0; k < 8; k++) begin
         arm_source_select = arm_codes[k];
         trigger_source_select = trg_codes[k];
         engine_reset(1'b1);
         drive_src((arm_codes[k] < 4) ? arm_codes[k] - 4'h1 : arm_codes[k], 1'b0, 1'b1);
         step(4);
         check(armed, 1'b1);
         drive_src(trg_codes[k], 1'b1, 1'b1);
         step(4);
         check({armed, busy, adjust_done_latched}, 3'b001);
         drive_src((arm_codes[k] < 4) ? arm_codes[k] - 4'h1 : arm_codes[k], 1'b0, 1'b0);
         drive_src(trg_codes[k], 1'b1, 1'b0);
         step(2);
      end
      // One pin arms on its rise and triggers on its fall
      trigger_invert = 1'b1;
      arm_source_select = 4'h4;
      trigger_source_select = 4'h4;
      engine_reset(1'b1);
      gpio[0] = 1'b1;
      step(4);
      check(armed, 1'b1);
      gpio[0] = 1'b0;
      step(4);
      check({armed, busy, adjust_done_latched}, 3'b001);
      trigger_invert = 1'b0;
      $display("source tests finished");
      // Arm refused without mode; pending arm cancelled by the reset bit
      arm_source_select = ARM_BIT_WRITE;
      trigger_source_select = TRG_BIT_WRITE;
      phase_mode = 1'b0;
      engine_reset(1'b1);
      arm_bit = 1'b1;
      step(4);
      check(armed, 1'b0);
      arm_bit = 1'b0;
      phase_mode = 1'b1;
      step(1);
      arm_bit = 1'b1;
      step(4);
      engine_reset(1'b0);
      trigger_bit = 1'b1;
      step(4);
      check({armed, busy, adjust_done_latched}, 3'b000);
      {arm_bit, trigger_bit} = 2'b00;
      $display("cancel test finished");
      // Steps of +1.0 and -1.0 fast periods; bypassed output is left alone
      apply('{0, 3, 0, 0, 0, 0, 0, 0, 0, 0, 0});
      medium_divider_value[2] = 7'h00;
      phase_step_amount = {8'h02, 8'hFE, 8'h02};
      step(100);
      arm_bit = 1'b1;
      step(2);
      trigger_bit = 1'b1;
      n = 0;
      while (adjust_done_latched !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      check(adjust_done_latched, 1'b1);
      step(7);
      check({hi_len[0], hi_len[1], hi_len[2]}, {16'h0006, 16'h0002, 16'h0001});
      check({busy, hi_len[2]}, {1'b0, 16'h0001});
      step(16);
      check(hi_len[0], 16'h0004);
      $display("phase step test finished");
      complete_run();
   end
endmodule // output_clock_divider_phase_adjust_bench
`default_nettype wire
